// ---- design/bpl_boot_loader.sv ----
`include "bpl_cfg.svh"

module bpl_boot_loader
  import bpl_pkg::*;
#(
  parameter bpl_variant_e VARIANT       = BPL_VAR_BASE,
  parameter logic [31:0]  EXT_EXEC_ADDR = 32'h0000_0000
) (
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic [2:0]  i_boot_select_pins,
  input  wire logic        i_src_valid,
  input  wire logic [15:0] i_src_data,
  input  wire logic        i_kernel_done,
  output logic             o_src_req,
  output logic [1:0]       o_src_width,
  output logic             o_eprom_cs,
  output logic             o_dma_active,
  output logic [3:0]       o_dma_channel,
  output logic [3:0]       o_dma_prog_channel,
  output logic             o_mem_we,
  output logic [31:0]      o_mem_addr,
  output logic [47:0]      o_mem_data,
  output logic             o_core_run,
  output logic [31:0]      o_exec_addr,
  output logic             o_ext_16bit,
  output logic             o_boot_busy,
  output logic             o_fault
);

  localparam logic [7:0] LAST_IDX = 8'(`BPL_KERNEL_WORDS - 1);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers. The data bus rides the first two of valid's three stages,
  // so it must be held steady around the rising edge of valid.

  logic [2:0]  pins_s1_q, pins_s2_q;
  logic        vld_s1_q, vld_s2_q, vld_s3_q;
  logic [15:0] dat_s1_q, dat_s2_q;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pins_s1_q <= 3'h0;
      pins_s2_q <= 3'h0;
      vld_s1_q  <= 1'b0;
      vld_s2_q  <= 1'b0;
      vld_s3_q  <= 1'b0;
      dat_s1_q  <= 16'h0000;
      dat_s2_q  <= 16'h0000;
    end else begin
      pins_s1_q <= i_boot_select_pins;
      pins_s2_q <= pins_s1_q;
      vld_s1_q  <= i_src_valid;
      vld_s2_q  <= vld_s1_q;
      vld_s3_q  <= vld_s2_q;
      dat_s1_q  <= i_src_data;
      dat_s2_q  <= dat_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Variant tables.

  function automatic logic [31:0] start_addr();
    case (VARIANT)
      BPL_VAR_REDUCED: start_addr = `BPL_START_REDUCED;
      BPL_VAR_WIDE:    start_addr = `BPL_START_WIDE;
      default:         start_addr = `BPL_START_BASE;
    endcase
  endfunction

  function automatic logic [3:0] chan_of(input bpl_mode_e m);
    case (VARIANT)
      BPL_VAR_WIDE:
        chan_of = (m == BPL_MODE_LINK) ? `BPL_CH_EIGHT : `BPL_CH_TEN;
      BPL_VAR_REDUCED: chan_of = `BPL_CH_EIGHT;
      default:         chan_of = `BPL_CH_SIX;
    endcase
  endfunction

  function automatic bpl_mode_e decode(input logic [2:0] p);
    case (p)
      3'h0:    decode = BPL_MODE_NONE;
      3'h1:    decode = BPL_MODE_EPROM;
      3'h2:    decode = BPL_MODE_HOST8;
      3'h3:    decode = BPL_MODE_HOST16;
      3'h4:    decode = BPL_MODE_LINK;
      default: decode = BPL_MODE_RSVD;
    endcase
  endfunction

  logic fam2;
  logic noboot_sel;
  logic link_ok;
  assign fam2 = (VARIANT == BPL_VAR_FAM2_3PIN) ||
                (VARIANT == BPL_VAR_FAM2_2PIN);
  assign noboot_sel = (VARIANT == BPL_VAR_FAM2_2PIN) ?
                      (pins_s2_q[1:0] == 2'h0) : (pins_s2_q == 3'h0);
  assign link_ok = (VARIANT != BPL_VAR_SINGLE_LINK) &&
                   (VARIANT != BPL_VAR_REDUCED);

  ////////////////////////////////////////////////////////////////////////
  // Kernel packer.

  logic        pk_valid;
  logic [47:0] pk_word;
  logic        pk_in;

  bpl_packer #(
    .WORD_W (`BPL_WORD_BITS)
  ) u_packer (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_valid (pk_in),
    .i_data  (dat_s2_q),
    .i_width (bpl_width_e'(o_src_width)),
    .o_valid (pk_valid),
    .o_word  (pk_word)
  );

  ////////////////////////////////////////////////////////////////////////
  // Boot sequencer.

  bpl_state_e  state_q, state_d;
  bpl_mode_e   mode;
  logic [1:0]  settle_q, settle_d;
  logic [7:0]  idx_q, idx_d;
  logic        req_q, req_d, cs_q, cs_d, dma_q, dma_d;
  logic [1:0]  width_q, width_d;
  logic [3:0]  ch_q, ch_d, prog_q, prog_d;
  logic        we_q, we_d, run_q, run_d, e16_q, e16_d;
  logic        busy_q, busy_d, fault_q, fault_d;
  logic [31:0] maddr_q, maddr_d, exec_q, exec_d;
  logic [47:0] mdata_q, mdata_d;

  assign mode  = decode(pins_s2_q);
  assign pk_in = req_q && vld_s2_q && !vld_s3_q;

  always_comb begin
    state_d  = state_q;
    settle_d = settle_q;
    idx_d    = idx_q;
    req_d    = req_q;
    cs_d     = cs_q;
    dma_d    = dma_q;
    width_d  = width_q;
    ch_d     = ch_q;
    prog_d   = prog_q;
    we_d     = 1'b0;
    maddr_d  = maddr_q;
    mdata_d  = mdata_q;
    run_d    = run_q;
    exec_d   = exec_q;
    e16_d    = e16_q;
    busy_d   = busy_q;
    fault_d  = fault_q;
    case (state_q)
      BPL_ST_SETTLE: begin
        settle_d = settle_q + 2'h1;
        if (settle_q == `BPL_SETTLE_CYCLES) begin
          if (noboot_sel) begin
            state_d = BPL_ST_NOBOOT;
            run_d   = 1'b1;
            busy_d  = 1'b0;
            exec_d  = fam2 ? `BPL_NOBOOT_FAM2 : EXT_EXEC_ADDR;
            e16_d   = fam2;
          end else if (!fam2 && (mode != BPL_MODE_RSVD) &&
                       (mode != BPL_MODE_LINK || link_ok)) begin
            state_d = BPL_ST_LOAD;
            req_d   = 1'b1;
            dma_d   = 1'b1;
            idx_d   = 8'h00;
            ch_d    = chan_of(mode);
            prog_d  = (VARIANT == BPL_VAR_REDUCED) ?
                      `BPL_CH_ZERO : chan_of(mode);
            cs_d    = (mode == BPL_MODE_EPROM);
            case (mode)
              BPL_MODE_EPROM:  width_d = BPL_W8;
              BPL_MODE_HOST16: width_d = BPL_W16;
              BPL_MODE_LINK:   width_d = BPL_W4;
              default:         width_d = BPL_W8;
            endcase
          end else begin
            // Reserved codes and unsupported modes park the loader.
            state_d = BPL_ST_FAULT;
            fault_d = 1'b1;
            busy_d  = 1'b0;
          end
        end
      end
      BPL_ST_LOAD: begin
        if (pk_valid) begin
          we_d    = 1'b1;
          maddr_d = start_addr() + {24'h000000, idx_q};
          mdata_d = pk_word;
          idx_d   = idx_q + 8'h01;
          if (idx_q == LAST_IDX) begin
            state_d = BPL_ST_KRUN;
            req_d   = 1'b0;
            run_d   = 1'b1;
            exec_d  = start_addr();
          end
        end
      end
      BPL_ST_KRUN: begin
        // Channel and chip select stay granted to the running kernel.
        if (i_kernel_done) begin
          state_d = BPL_ST_APP;
          dma_d   = 1'b0;
          cs_d    = 1'b0;
          busy_d  = 1'b0;
          exec_d  = start_addr();
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_q  <= BPL_ST_SETTLE;
      settle_q <= 2'h0;
      idx_q    <= 8'h00;
      req_q    <= 1'b0;
      cs_q     <= 1'b0;
      dma_q    <= 1'b0;
      width_q  <= BPL_W8;
      ch_q     <= 4'h0;
      prog_q   <= 4'h0;
      we_q     <= 1'b0;
      maddr_q  <= 32'h0000_0000;
      mdata_q  <= 48'h0000_0000_0000;
      run_q    <= 1'b0;
      exec_q   <= 32'h0000_0000;
      e16_q    <= 1'b0;
      busy_q   <= 1'b1;
      fault_q  <= 1'b0;
    end else begin
      state_q  <= state_d;
      settle_q <= settle_d;
      idx_q    <= idx_d;
      req_q    <= req_d;
      cs_q     <= cs_d;
      dma_q    <= dma_d;
      width_q  <= width_d;
      ch_q     <= ch_d;
      prog_q   <= prog_d;
      we_q     <= we_d;
      maddr_q  <= maddr_d;
      mdata_q  <= mdata_d;
      run_q    <= run_d;
      exec_q   <= exec_d;
      e16_q    <= e16_d;
      busy_q   <= busy_d;
      fault_q  <= fault_d;
    end
  end

  assign o_src_req          = req_q;
  assign o_src_width        = width_q;
  assign o_eprom_cs         = cs_q;
  assign o_dma_active       = dma_q;
  assign o_dma_channel      = ch_q;
  assign o_dma_prog_channel = prog_q;
  assign o_mem_we           = we_q;
  assign o_mem_addr         = maddr_q;
  assign o_mem_data         = mdata_q;
  assign o_core_run         = run_q;
  assign o_exec_addr        = exec_q;
  assign o_ext_16bit        = e16_q;
  assign o_boot_busy        = busy_q;
  assign o_fault            = fault_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  logic [8:0] wr_cnt_q;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      wr_cnt_q <= 9'h000;
    end else if (we_q) begin
      wr_cnt_q <= wr_cnt_q + 9'h001;
    end
  end

  // The last word's write pulse is still out on the first kernel cycle.
  a_kernel_word_count: assert property (
    (state_q == BPL_ST_KRUN)
      |-> ((wr_cnt_q + {8'h00, we_q}) == 9'(`BPL_KERNEL_WORDS)))
    else $error("kernel run began without exactly 256 words");
  a_eprom_byte_wide: assert property (
    (state_q == BPL_ST_LOAD && cs_q) |-> (width_q == BPL_W8))
    else $error("eprom load not 8 bits wide");
  a_host_bus_width: assert property (
    (state_q == BPL_ST_LOAD && !cs_q) |-> (width_q != BPL_W4
      || ch_q == ((VARIANT == BPL_VAR_WIDE) ? `BPL_CH_EIGHT : `BPL_CH_SIX)))
    else $error("host load width wrong");
  a_link_nibble_width: assert property (
    (state_q == BPL_ST_LOAD && width_q == BPL_W4) |-> link_ok)
    else $error("nibble link load on a variant without link boot");
  a_noboot_no_load: assert property (
    (state_q == BPL_ST_NOBOOT) |-> (run_q && !we_q && !req_q && !dma_q))
    else $error("no-boot touched the kernel path");
  a_channel_map: assert property (
    $rose(req_q) |-> (ch_q == chan_of(decode(pins_s2_q))))
    else $error("boot channel does not match variant");
  a_reduced_prog_chan: assert property (
    $rose(dma_q) |-> ((VARIANT == BPL_VAR_REDUCED) ?
      (prog_q == `BPL_CH_ZERO && ch_q == `BPL_CH_EIGHT) : (prog_q == ch_q)))
    else $error("channel programming path wrong");
  a_kernel_handoff: assert property (
    (state_q == BPL_ST_LOAD && pk_valid && idx_q == LAST_IDX)
      |=> (run_q && !req_q && exec_q == start_addr()) [*2])
    else $error("kernel did not start after last word");
  a_app_start: assert property (
    (state_q == BPL_ST_KRUN && i_kernel_done)
      |=> (state_q == BPL_ST_APP && exec_q == start_addr() && !busy_q))
    else $error("application did not start at its address");
  a_vector_skipped: assert property (
    (run_q && busy_q) |-> (exec_q != start_addr() + `BPL_VECTOR_OFS))
    else $error("reset vector reached during boot");
  a_fam2_direct_fetch: assert property (
    (state_q == BPL_ST_NOBOOT && fam2)
      |-> (exec_q == `BPL_NOBOOT_FAM2 && e16_q))
    else $error("second family no-boot fetch wrong");

  c_kernel_loaded: cover property (state_q == BPL_ST_KRUN);
  c_app_running:   cover property ($rose(state_q == BPL_ST_APP));
  c_noboot:        cover property (state_q == BPL_ST_NOBOOT);
  c_fault:         cover property (state_q == BPL_ST_FAULT);

endmodule

// ---- design/bpl_cfg.svh ----
`ifndef BPL_CFG_SVH
`define BPL_CFG_SVH

// Kernel image size and word width.
`define BPL_KERNEL_WORDS  256
`define BPL_WORD_BITS     48

// Start addresses per variant; the reset vector sits four above.
`define BPL_START_BASE    32'h0002_0000
`define BPL_START_REDUCED 32'h0000_8000
`define BPL_START_WIDE    32'h0004_0000
`define BPL_VECTOR_OFS    32'h0000_0004

// Direct-fetch address of the second family in no-boot mode.
`define BPL_NOBOOT_FAM2   32'h2000_0000

// Boot DMA channel numbers.
`define BPL_CH_ZERO       4'h0
`define BPL_CH_SIX        4'h6
`define BPL_CH_EIGHT      4'h8
`define BPL_CH_TEN        4'ha

// Cycles the synchronised boot pins settle before they are decoded.
`define BPL_SETTLE_CYCLES 2'h3

`endif

// ---- design/bpl_packer.sv ----
`include "bpl_cfg.svh"

module bpl_packer
  import bpl_pkg::*;
#(
  parameter int WORD_W = `BPL_WORD_BITS
) (
  input  wire logic              i_mclk,
  input  wire logic              i_rst,
  input  wire logic              i_valid,
  input  wire logic [15:0]       i_data,
  input  wire bpl_width_e        i_width,
  output logic                   o_valid,
  output logic [WORD_W-1:0]      o_word
);

  logic [5:0]        bits_q, bits_d;
  logic [WORD_W-1:0] word_q, word_d;
  logic              valid_q, valid_d;

  // The first unit received ends up in the least significant bits.
  always_comb begin
    bits_d  = bits_q;
    word_d  = word_q;
    valid_d = 1'b0;
    if (i_valid) begin
      case (i_width)
        BPL_W4: begin
          word_d = {i_data[3:0], word_q[WORD_W-1:4]};
          bits_d = bits_q + 6'h04;
        end
        BPL_W8: begin
          word_d = {i_data[7:0], word_q[WORD_W-1:8]};
          bits_d = bits_q + 6'h08;
        end
        default: begin
          word_d = {i_data, word_q[WORD_W-1:16]};
          bits_d = bits_q + 6'h10;
        end
      endcase
      if (bits_d == 6'(WORD_W)) begin
        valid_d = 1'b1;
        bits_d  = 6'h00;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      bits_q  <= 6'h00;
      word_q  <= '0;
      valid_q <= 1'b0;
    end else begin
      bits_q  <= bits_d;
      word_q  <= word_d;
      valid_q <= valid_d;
    end
  end

  assign o_valid = valid_q;
  assign o_word  = word_q;

endmodule

// ---- design/bpl_pkg.sv ----
package bpl_pkg;

  typedef enum logic [2:0] {
    BPL_VAR_BASE        = 3'h0,
    BPL_VAR_SINGLE_LINK = 3'h1,
    BPL_VAR_REDUCED     = 3'h2,
    BPL_VAR_WIDE        = 3'h3,
    BPL_VAR_FAM2_3PIN   = 3'h4,
    BPL_VAR_FAM2_2PIN   = 3'h5
  } bpl_variant_e;

  // Codes equal the boot select pin values of the first family.
  typedef enum logic [2:0] {
    BPL_MODE_NONE   = 3'h0,
    BPL_MODE_EPROM  = 3'h1,
    BPL_MODE_HOST8  = 3'h2,
    BPL_MODE_HOST16 = 3'h3,
    BPL_MODE_LINK   = 3'h4,
    BPL_MODE_RSVD   = 3'h7
  } bpl_mode_e;

  typedef enum logic [1:0] {
    BPL_W4  = 2'h0,
    BPL_W8  = 2'h1,
    BPL_W16 = 2'h2
  } bpl_width_e;

  typedef enum logic [5:0] {
    BPL_ST_SETTLE = 6'h01,
    BPL_ST_LOAD   = 6'h02,
    BPL_ST_KRUN   = 6'h04,
    BPL_ST_APP    = 6'h08,
    BPL_ST_NOBOOT = 6'h10,
    BPL_ST_FAULT  = 6'h20
  } bpl_state_e;

endpackage

// ---- sim/bpl_src_model.sv ----
// Boot source on the far side: EPROM, host or link peer, one unit a strobe.
module bpl_src_model
  import bpl_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic        i_req,
  input  wire logic [3:0]  i_gap,
  output logic             o_valid,
  output logic [15:0]      o_data
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [2:0] ph_q;
  logic [3:0] wait_q;
  int         unit_q;

  function automatic logic [15:0] unit_val(input int k);
    return 16'(k * 40503 + 4660);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Data leads the strobe by a cycle and stays until it has been taken.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ph_q <= 3'h0;
      wait_q <= 4'h0;
      unit_q <= 0;
      o_valid <= 1'b0;
      o_data <= 16'h0;
    end else begin
      case (ph_q)
        3'h0: begin
          if (i_req) begin
            o_data <= unit_val(unit_q);
            ph_q <= 3'h1;
          end else begin
            // Released lines wander so that a stale value never passes.
            o_data <= ~o_data;
          end
        end
        3'h1: begin
          o_valid <= 1'b1;
          ph_q <= 3'h2;
        end
        3'h2: ph_q <= 3'h3;
        3'h3: begin
          o_valid <= 1'b0;
          unit_q <= unit_q + 1;
          wait_q <= i_gap;
          ph_q <= 3'h4;
        end
        default: begin
          if (wait_q == 4'h0) ph_q <= 3'h0;
          else wait_q <= wait_q - 4'h1;
        end
      endcase
    end
  end
endmodule

// ---- sim/tb_bpl_boot_loader.sv ----
`include "bpl_cfg.svh"
module tb_bpl_boot_loader
  import bpl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [31:0] EXT_ADDR = 32'h0001_2340;
  localparam int          NV       = 6;
  localparam logic [31:0] START    = `BPL_START_BASE;
  localparam logic [31:0] RED_ST   = `BPL_START_REDUCED;
  localparam logic [31:0] WIDE_ST  = `BPL_START_WIDE;
  localparam logic [31:0] FAM2_ADDR = `BPL_NOBOOT_FAM2;

  logic          mclk;
  logic          rst;
  logic          kd;
  logic [2:0]    pins;
  logic          valid;
  logic [15:0]   data;
  logic [3:0]    gap;
  logic [NV-1:0] req, cs, dma, we, run, e16, busy, fault;
  logic [1:0]    wid [NV];
  logic [3:0]    ch [NV];
  logic [3:0]    pch [NV];
  logic [31:0]   addr [NV];
  logic [31:0]   xa [NV];
  logic [47:0]   mdat [NV];
  int            failures, tests_run, widx, cur_n, cur_b;

  ////////////////////////////////////////////////////////////////////////////
  // One instance per variant; all share pins, reset and source lines.
  for (genvar g = 0; g < NV; g++) begin : g_var
    bpl_boot_loader #(
      .VARIANT       (bpl_variant_e'(g)),
      .EXT_EXEC_ADDR (EXT_ADDR)
    ) u_bpl_boot_loader (
      .i_mclk(mclk), .i_rst(rst), .i_boot_select_pins(pins),
      .i_src_valid(valid), .i_src_data(data), .i_kernel_done(kd),
      .o_src_req(req[g]), .o_src_width(wid[g]), .o_eprom_cs(cs[g]),
      .o_dma_active(dma[g]), .o_dma_channel(ch[g]),
      .o_dma_prog_channel(pch[g]), .o_mem_we(we[g]),
      .o_mem_addr(addr[g]), .o_mem_data(mdat[g]), .o_core_run(run[g]),
      .o_exec_addr(xa[g]), .o_ext_16bit(e16[g]), .o_boot_busy(busy[g]),
      .o_fault(fault[g])
    );
  end

  bpl_src_model u_bpl_src_model (
    .i_mclk(mclk), .i_rst(rst), .i_req(req[0]), .i_gap(gap),
    .o_valid(valid), .o_data(data)
  );

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] unit_val(input int k);
    return 16'(k * 40503 + 4660);
  endfunction

  // First unit lands in the low bits of the word.
  function automatic logic [47:0] exp_word(input int w);
    logic [47:0] acc;
    logic [31:0] u;
    acc = '0;
    for (int j = 0; j < cur_n; j++) begin
      u = 32'(unit_val(w * cur_n + j)) & ((32'h1 << cur_b) - 32'h1);
      acc = acc | (48'(u) << (j * cur_b));
    end
    return acc;
  endfunction

  task automatic chk(input string nm, input logic [47:0] seen,
                     input logic [47:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("Checks run %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(negedge mclk) begin
    if (rst) begin
      widx = 0;
    end else if (we[0] === 1'b1) begin
      chk("mem_addr", 48'(addr[0]), 48'(START + 32'(widx)));
      chk("mem_data", mdat[0], exp_word(widx));
      chk("wide_we", 48'(we[3]), 48'h1);
      chk("wide_addr", 48'(addr[3]), 48'(WIDE_ST + 32'(widx)));
      widx = widx + 1;
    end
  end

  task automatic do_reset(input logic [2:0] p);
    @(posedge mclk);
    pins <= p;
    rst <= 1'b1;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic pulse_done();
    @(posedge mclk);
    kd <= 1'b1;
    @(posedge mclk);
    kd <= 1'b0;
    @(posedge mclk);
    @(negedge mclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Every pin code on every variant.
  task automatic decode_all();
    logic [2:0] code;
    logic       fam2, nob, flt;
    logic [3:0] chn;
    for (int p = 0; p < 8; p++) begin
      do_reset(3'(p));
      for (int v = 0; v < NV; v++) begin
        fam2 = (v >= 4);
        code = (v == 5) ? {1'b0, 2'(p)} : 3'(p);
        nob = (code == 3'h0);
        flt = fam2 ? !nob : (p >= 5 || (p == 4 && (v == 1 || v == 2)));
        chn = (v == 3) ? ((p == 4) ? 4'h8 : 4'ha) : ((v == 2) ? 4'h8 : 4'h6);
        chk("fault", 48'(fault[v]), 48'(flt));
        chk("core_run", 48'(run[v]), 48'(nob));
        chk("busy", 48'(busy[v]), 48'(!(flt || nob)));
        if (nob) begin
          chk("exec", 48'(xa[v]), 48'(fam2 ? FAM2_ADDR : EXT_ADDR));
          chk("ext16", 48'(e16[v]), 48'(fam2));
          chk("req_nb", 48'(req[v]), 48'h0);
        end else if (!flt) begin
          chk("chan", 48'(ch[v]), 48'(chn));
          chk("pchan", 48'(pch[v]), 48'((v == 2) ? 4'h0 : chn));
          chk("req", 48'(req[v]), 48'h1);
          chk("dma", 48'(dma[v]), 48'h1);
          chk("cs", 48'(cs[v]), 48'(p == 1));
          chk("width", 48'(wid[v]),
              48'((p == 4) ? 2'h0 : (p == 3) ? 2'h2 : 2'h1));
        end
      end
      if (p == 0) chk("words_nb", 48'(widx), 48'h0);
    end
  endtask

  // Full kernel load, an ignored early done, then the hand-over.
  task automatic load_run(input logic [2:0] p, input int n, input int b,
                          input logic [3:0] g);
    int cnt;
    cur_n = n;
    cur_b = b;
    gap <= g;
    do_reset(p);
    repeat (100) @(posedge mclk);
    pulse_done();
    chk("busy_early", 48'(busy[0]), 48'h1);
    chk("req_early", 48'(req[0]), 48'h1);
    cnt = 0;
    while (run[0] !== 1'b1 && cnt < 40000) begin
      @(negedge mclk);
      cnt++;
    end
    // A load that never finishes counts against the run here.
    chk("load_done", 48'(run[0]), 48'h1);
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk("words", 48'(widx), 48'(`BPL_KERNEL_WORDS));
    chk("req_end", 48'(req[0]), 48'h0);
    chk("kexec", 48'(xa[0]), 48'(START));
    chk("kexec_wide", 48'(xa[3]), 48'(WIDE_ST));
    chk("vector", 48'(xa[0] == START + `BPL_VECTOR_OFS), 48'h0);
    chk("busy_k", 48'(busy[0]), 48'h1);
    chk("dma_k", 48'(dma[0]), 48'h1);
    chk("cs_k", 48'(cs[0]), 48'(p == 3'h1));
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    chk("words_after", 48'(widx), 48'(`BPL_KERNEL_WORDS));
    pulse_done();
    chk("busy_app", 48'(busy[0]), 48'h0);
    chk("dma_app", 48'(dma[0]), 48'h0);
    chk("cs_app", 48'(cs[0]), 48'h0);
    chk("app_addr", 48'(xa[0]), 48'(START));
    chk("run_app", 48'(run[0]), 48'h1);
    chk("app_wide", 48'(xa[3]), 48'(WIDE_ST));
    chk("busy_wide", 48'(busy[3]), 48'h0);
    if (p != 3'h4) chk("app_red", 48'(xa[2]), 48'(RED_ST));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    kd = 1'b0;
    pins = 3'h0;
    gap = 4'h0;
    failures = 0;
    tests_run = 0;
    widx = 0;
    cur_n = 6;
    cur_b = 8;
    decode_all();
    load_run(3'h1, 6, 8, 4'h0);
    load_run(3'h3, 3, 16, 4'h5);
    load_run(3'h4, 12, 4, 4'h0);
    print_verdict();
  end

  // The run needs about 32k cycles; this allows under three times as many.
  initial begin
    #450_000;
    failures++;
    print_verdict();
  end
endmodule
